// >>> hw/pmd_decoder.sv
// Purpose: decode of the privileged library-mode opcodes with privilege
//          check, full load/store field decode and effective address
// Assumes: issue presents one instruction a cycle with operand values
// Notes:   one-cycle latency; registers over AXI4-Lite
//
// Behaviour
// - Opcode 1e decodes as the privileged return.
// - Opcode 19 decodes as internal-register read into a general register.
// - Opcode 1d decodes as internal-register write from a general register.
// - Privileged opcodes outside library mode raise the reserved-opcode fault.
// - With kernel hardware enable set, kernel mode may use them too.
// - Load opcode 1b; bits 25:21 destination, 20:16 base register.
// - Privileged load never takes an alignment trap.
// - Bit 12 picks longword or quadword; bits 11:0 signed displacement.
// - Load types 000 physical, 001 physical with load-locked.
// - Load type 010 is a flagged page-entry fetch, kernel checks.
// - Load type 100 virtual; 101 virtual with fault and protection checks.
// - Load types 110, 111 use alternate mode; 111 adds protection checks.
// - Store opcode 1f; 25:21 data, 20:16 base, same length and offset.
// - Privileged store never takes an alignment trap.
// - Store type 000 physical, 010 virtual.
// - Store type 001 is physical store-conditional returning lock flag.
// - Store type 110 virtual with alternate-mode access checks.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pmd_map.svh"

module pmd_decoder (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Issue side
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_instr,
    input  wire logic [63:0]       base_value,
    input  wire logic              library_mode,
    input  wire logic              kernel_mode,
    // Decode result
    output pmd_pkg::pmd_dec_s      dec_out,
    output logic                   reserved_opcode_fault,
    // Interrupt
    output logic                   irq,
    // AXI4-Lite slave
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic is_priv_op(input logic [5:0] op);
        is_priv_op = (op == `PMD_OP_LOAD) || (op == `PMD_OP_STORE) ||
                     (op == `PMD_OP_RETURN) || (op == `PMD_OP_IREAD) ||
                     (op == `PMD_OP_IWRITE);
    endfunction

    function automatic logic [63:0] sext_byte_displacement(input logic [11:0] d);
        sext_byte_displacement = {{52{d[`PMD_BYTE_DISPLACEMENT_SIGN]}}, d};
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    pmd_pkg::pmd_state_s st_q;
    pmd_pkg::pmd_state_s st_d;

    logic [5:0]  opcode;
    logic [2:0]  acc_type;
    logic        priv_op;
    logic        allowed;
    logic        wr_go;
    logic        rd_go;
    logic [3:0]  ev;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic        rd_hit;

    assign opcode   = issue_instr[`PMD_OP_HI:`PMD_OP_LO];
    assign acc_type = issue_instr[`PMD_TYPE_HI:`PMD_TYPE_LO];
    assign priv_op  = is_priv_op(opcode);
    assign allowed  = library_mode ||
                      (kernel_mode && st_q.regs.hw_enable);

    assign wr_go  = st_q.bus.aw_held && st_q.bus.w_held && !st_q.bus.bvalid;
    assign rd_go  = s_axi_arvalid && !st_q.bus.rvalid;
    assign wr_val = lane_merge(32'h0000_0000, st_q.bus.w_data,
                               st_q.bus.w_strb);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `PMD_REG_CTRL:  rd_val = {31'h0, st_q.regs.hw_enable};
            `PMD_REG_STAT:  rd_val = {28'h0, st_q.regs.status};
            `PMD_REG_MASK:  rd_val = {28'h0, st_q.regs.mask};
            `PMD_REG_COUNT: rd_val = {16'h0, st_q.regs.fault_count};
            default:        rd_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        ev   = 4'h0;

        // Decode stage
        st_d.dec = '0;
        st_d.dec.valid     = issue_valid;
        st_d.dec.data_reg  = issue_instr[`PMD_RA_HI:`PMD_RA_LO];
        st_d.dec.base_reg  = issue_instr[`PMD_RB_HI:`PMD_RB_LO];
        st_d.dec.acc_type  = acc_type;
        st_d.dec.quad      = issue_instr[`PMD_LEN_BIT];
        st_d.dec.eff_addr  = base_value +
                             sext_byte_displacement(issue_instr[`PMD_BYTE_DISPLACEMENT_HI:0]);
        st_d.dec.align_trap_en = 1'b1;
        st_d.dec.amode     = pmd_pkg::PMD_AM_PHYS;

        if (issue_valid && priv_op && !allowed) begin
            st_d.dec.fault = 1'b1;
            st_d.dec.kind  = pmd_pkg::PMD_NONE;
            ev[`PMD_ST_FAULT] = 1'b1;
        end else if (issue_valid) begin
            case (opcode)
                `PMD_OP_RETURN: st_d.dec.kind = pmd_pkg::PMD_RETURN;
                `PMD_OP_IREAD:  st_d.dec.kind = pmd_pkg::PMD_IREAD;
                `PMD_OP_IWRITE: st_d.dec.kind = pmd_pkg::PMD_IWRITE;
                `PMD_OP_LOAD: begin
                    st_d.dec.kind = pmd_pkg::PMD_LOAD;
                    st_d.dec.align_trap_en = 1'b0;
                    ev[`PMD_ST_LOAD] = 1'b1;
                    case (acc_type)
                        `PMD_TY_PHYS:  st_d.dec.amode = pmd_pkg::PMD_AM_PHYS;
                        `PMD_TY_PLOCK: begin
                            st_d.dec.amode = pmd_pkg::PMD_AM_PHYS;
                            st_d.dec.lock  = 1'b1;
                        end
                        `PMD_TY_VPTE: begin
                            st_d.dec.amode      = pmd_pkg::PMD_AM_VIRT;
                            st_d.dec.pte_fetch  = 1'b1;
                            st_d.dec.kern_check = 1'b1;
                        end
                        `PMD_TY_VIRT:  st_d.dec.amode = pmd_pkg::PMD_AM_VIRT;
                        `PMD_TY_VCHK: begin
                            st_d.dec.amode      = pmd_pkg::PMD_AM_VIRT;
                            st_d.dec.prot_check = 1'b1;
                        end
                        `PMD_TY_ALT:   st_d.dec.amode = pmd_pkg::PMD_AM_ALT;
                        `PMD_TY_ALTCHK: begin
                            st_d.dec.amode      = pmd_pkg::PMD_AM_ALT;
                            st_d.dec.prot_check = 1'b1;
                        end
                        default: st_d.dec.amode = pmd_pkg::PMD_AM_VIRT;
                    endcase
                end
                `PMD_OP_STORE: begin
                    st_d.dec.kind = pmd_pkg::PMD_STORE;
                    st_d.dec.align_trap_en = 1'b0;
                    ev[`PMD_ST_STORE] = 1'b1;
                    case (acc_type)
                        `PMD_TY_PHYS:    st_d.dec.amode = pmd_pkg::PMD_AM_PHYS;
                        `PMD_TY_VIRT_ST: st_d.dec.amode = pmd_pkg::PMD_AM_VIRT;
                        `PMD_TY_PLOCK: begin
                            st_d.dec.amode      = pmd_pkg::PMD_AM_PHYS;
                            st_d.dec.cond_store = 1'b1;
                        end
                        `PMD_TY_ALT:     st_d.dec.amode = pmd_pkg::PMD_AM_ALT;
                        default: begin
                            st_d.dec.bad_store_type = 1'b1;
                            ev[`PMD_ST_BADST] = 1'b1;
                        end
                    endcase
                end
                default: st_d.dec.kind = pmd_pkg::PMD_NONE;
            endcase
        end

        if (ev[`PMD_ST_FAULT]) begin
            st_d.regs.fault_count = st_q.regs.fault_count + 16'h0001;
        end

        // Write channel capture
        if (s_axi_awvalid && !st_q.bus.aw_held) begin
            st_d.bus.aw_held = 1'b1;
            st_d.bus.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.bus.w_held) begin
            st_d.bus.w_held = 1'b1;
            st_d.bus.w_data = s_axi_wdata;
            st_d.bus.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            st_d.bus.aw_held = 1'b0;
            st_d.bus.w_held  = 1'b0;
            st_d.bus.bvalid  = 1'b1;
            st_d.bus.bresp   = `PMD_RESP_OKAY;
            case (st_q.bus.aw_addr)
                `PMD_REG_CTRL:
                    if (st_q.bus.w_strb[0]) begin
                        st_d.regs.hw_enable = st_q.bus.w_data[0];
                    end
                `PMD_REG_STAT:
                    st_d.regs.status = st_q.regs.status & ~wr_val[3:0];
                `PMD_REG_MASK:
                    if (st_q.bus.w_strb[0]) begin
                        st_d.regs.mask = st_q.bus.w_data[3:0];
                    end
                `PMD_REG_COUNT:
                    st_d.regs.fault_count = 16'h0000;
                default: st_d.bus.bresp = `PMD_RESP_SLVERR;
            endcase
        end
        if (st_q.bus.bvalid && s_axi_bready) begin
            st_d.bus.bvalid = 1'b0;
        end

        // Hardware set wins over a software clear
        st_d.regs.status = st_d.regs.status | ev;

        // Read channel
        if (rd_go) begin
            st_d.bus.rvalid = 1'b1;
            st_d.bus.rdata  = rd_val;
            st_d.bus.rresp  = rd_hit ? `PMD_RESP_OKAY : `PMD_RESP_SLVERR;
        end else if (st_q.bus.rvalid && s_axi_rready) begin
            st_d.bus.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.regs.hw_enable <= `PMD_CTRL_RST;
            st_q.regs.mask      <= `PMD_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign dec_out               = st_q.dec;
    assign reserved_opcode_fault = st_q.dec.fault;
    assign irq           = |(st_q.regs.status & st_q.regs.mask);
    assign s_axi_awready = !st_q.bus.aw_held;
    assign s_axi_wready  = !st_q.bus.w_held;
    assign s_axi_bvalid  = st_q.bus.bvalid;
    assign s_axi_bresp   = st_q.bus.bresp;
    assign s_axi_arready = !st_q.bus.rvalid;
    assign s_axi_rvalid  = st_q.bus.rvalid;
    assign s_axi_rdata   = st_q.bus.rdata;
    assign s_axi_rresp   = st_q.bus.rresp;

endmodule

// >>> hw/pmd_map.svh
// Purpose: constants for the privileged memory-op decoder
// Assumes: 32-bit instruction words
// Notes:   offsets are AXI4-Lite byte addresses
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH

`define PMD_OP_LOAD      6'h1b
`define PMD_OP_STORE     6'h1f
`define PMD_OP_RETURN    6'h1e
`define PMD_OP_IREAD     6'h19
`define PMD_OP_IWRITE    6'h1d

`define PMD_OP_HI        31
`define PMD_OP_LO        26
`define PMD_RA_HI        25
`define PMD_RA_LO        21
`define PMD_RB_HI        20
`define PMD_RB_LO        16
`define PMD_TYPE_HI      15
`define PMD_TYPE_LO      13
`define PMD_LEN_BIT      12
`define PMD_BYTE_DISPLACEMENT_HI      11
`define PMD_BYTE_DISPLACEMENT_SIGN    11

`define PMD_TY_PHYS      3'h0
`define PMD_TY_PLOCK     3'h1
`define PMD_TY_VPTE      3'h2
`define PMD_TY_VIRT_ST   3'h2
`define PMD_TY_VIRT      3'h4
`define PMD_TY_VCHK      3'h5
`define PMD_TY_ALT       3'h6
`define PMD_TY_ALTCHK    3'h7

`define PMD_REG_CTRL     4'h0
`define PMD_REG_STAT     4'h4
`define PMD_REG_MASK     4'h8
`define PMD_REG_COUNT    4'hc

`define PMD_CTRL_RST     1'h0
`define PMD_MASK_RST     4'h0
`define PMD_ST_FAULT     0
`define PMD_ST_LOAD      1
`define PMD_ST_STORE     2
`define PMD_ST_BADST     3

`define PMD_RESP_OKAY    2'h0
`define PMD_RESP_SLVERR  2'h2

`endif

// >>> hw/pmd_pkg.sv
// Purpose: types for the privileged memory-op decoder
// Assumes: included map header holds the numbers
// Notes:   none
package pmd_pkg;

    typedef enum logic [2:0] {
        PMD_NONE   = 3'h0,
        PMD_LOAD   = 3'h1,
        PMD_STORE  = 3'h2,
        PMD_RETURN = 3'h3,
        PMD_IREAD  = 3'h4,
        PMD_IWRITE = 3'h5
    } pmd_kind_e;

    typedef enum logic [1:0] {
        PMD_AM_PHYS = 2'h0,
        PMD_AM_VIRT = 2'h1,
        PMD_AM_ALT  = 2'h2
    } pmd_amode_e;

    // One decoded instruction handed to memory and translation
    typedef struct packed {
        logic       valid;
        pmd_kind_e  kind;
        logic       fault;
        logic [4:0] data_reg;
        logic [4:0] base_reg;
        logic [2:0] acc_type;
        logic       quad;
        logic [63:0] eff_addr;
        pmd_amode_e amode;
        logic       lock;
        logic       cond_store;
        logic       pte_fetch;
        logic       kern_check;
        logic       prot_check;
        logic       align_trap_en;
        logic       bad_store_type;
    } pmd_dec_s;

    // Software-visible state
    typedef struct packed {
        logic        hw_enable;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic [15:0] fault_count;
    } pmd_regs_s;

    // Bus slave state
    typedef struct packed {
        logic        aw_held;
        logic [3:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pmd_bus_s;

    typedef struct packed {
        pmd_dec_s  dec;
        pmd_regs_s regs;
        pmd_bus_s  bus;
    } pmd_state_s;

endpackage

// >>> verif/pmd_decoder_properties.sv
// Purpose: port-level checks of the privileged memory-op decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   decode answers exactly one cycle after issue
`timescale 1ns/1ps
module pmd_decoder_checker (
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Issue side
    input wire logic              issue_valid,
    input wire logic [31:0]       issue_instr,
    input wire logic [63:0]       base_value,
    input wire logic              library_mode,
    input wire logic              kernel_mode,
    // Decode result
    input wire pmd_pkg::pmd_dec_s dec_out,
    input wire logic              reserved_opcode_fault
);
    // ****************************************
    // Issue qualifiers
    // ****************************************
    logic [5:0] op;
    logic [2:0] ty;
    logic       lib_go;
    logic       priv;
    assign op     = issue_instr[31:26];
    assign ty     = issue_instr[15:13];
    assign lib_go = issue_valid && library_mode;
    assign priv   = op inside {6'h1b, 6'h1f, 6'h1e, 6'h19, 6'h1d};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Decode checks
    // ****************************************
    priv_fault_a: assert property (
        issue_valid && priv && !library_mode && !kernel_mode |=>
        reserved_opcode_fault && dec_out.kind == pmd_pkg::PMD_NONE)
        else $error("privileged opcode not refused");
    nonpriv_quiet_a: assert property (
        issue_valid && !priv |=> !reserved_opcode_fault)
        else $error("fault on ordinary opcode");
    ret_kind_a: assert property (
        lib_go && op == 6'h1e |=> dec_out.kind == pmd_pkg::PMD_RETURN)
        else $error("return not decoded");
    iread_kind_a: assert property (
        lib_go && op == 6'h19 |=> dec_out.kind == pmd_pkg::PMD_IREAD)
        else $error("register read not decoded");
    iwrite_kind_a: assert property (
        lib_go && op == 6'h1d |=> dec_out.kind == pmd_pkg::PMD_IWRITE)
        else $error("register write not decoded");
    load_fields_a: assert property (
        lib_go && op == 6'h1b |=> dec_out.kind == pmd_pkg::PMD_LOAD &&
        dec_out.data_reg == $past(issue_instr[25:21]) &&
        dec_out.base_reg == $past(issue_instr[20:16]) &&
        dec_out.quad == $past(issue_instr[12]) && !dec_out.align_trap_en)
        else $error("load fields wrong");
    store_fields_a: assert property (
        lib_go && op == 6'h1f |=> dec_out.kind == pmd_pkg::PMD_STORE &&
        dec_out.data_reg == $past(issue_instr[25:21]) &&
        !dec_out.align_trap_en)
        else $error("store fields wrong");
    eff_addr_a: assert property (
        issue_valid |=> dec_out.eff_addr == $past(base_value) +
        {{52{$past(issue_instr[11])}}, $past(issue_instr[11:0])})
        else $error("effective address wrong");
    vpte_load_a: assert property (
        lib_go && op == 6'h1b && ty == 3'h2 |=> dec_out.pte_fetch &&
        dec_out.kern_check && dec_out.amode == pmd_pkg::PMD_AM_VIRT)
        else $error("page entry fetch not flagged");
    alt_load_a: assert property (
        lib_go && op == 6'h1b && ty[2:1] == 2'b11 |=>
        dec_out.amode == pmd_pkg::PMD_AM_ALT &&
        dec_out.prot_check == $past(issue_instr[13]))
        else $error("alternate mode load wrong");
    cond_store_a: assert property (
        lib_go && op == 6'h1f && ty == 3'h1 |=> dec_out.cond_store &&
        dec_out.amode == pmd_pkg::PMD_AM_PHYS)
        else $error("conditional store wrong");
endmodule

bind pmd_decoder pmd_decoder_checker u_chk (
    .aclk, .aresetn, .issue_valid, .issue_instr, .base_value,
    .library_mode, .kernel_mode, .dec_out, .reserved_opcode_fault
);

// >>> verif/pmd_testbench.sv
// Purpose: self-checking bench of the privileged memory-op decoder
// Assumes: 100 MHz clock, registers reached over AXI4-Lite
// Notes:   decode rows issue back to back, one each cycle
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [31:0] instr;
        logic [1:0]  md;
        logic [2:0]  kind;
        logic        flt;
        logic [1:0]  am;
        logic [5:0]  fl;
    } pmd_row_s;
    localparam logic [2:0] k_no = pmd_pkg::PMD_NONE;
    localparam logic [2:0] k_ld = pmd_pkg::PMD_LOAD;
    localparam logic [2:0] k_st = pmd_pkg::PMD_STORE;
    localparam logic [2:0] k_rt = pmd_pkg::PMD_RETURN;
    logic              aclk, aresetn, issue_valid, library_mode, kernel_mode;
    logic [31:0]       issue_instr, s_axi_wdata, s_axi_rdata;
    logic [63:0]       base_value;
    pmd_pkg::pmd_dec_s dec_out;
    logic              reserved_opcode_fault, irq;
    logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready;
    int                bad_count;
    int                n_checks;
    pmd_row_s          q[$];

    pmd_decoder u_dut (
        .aclk, .aresetn, .issue_valid, .issue_instr, .base_value,
        .library_mode, .kernel_mode, .dec_out, .reserved_opcode_fault, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic pmd_row_s mk(input logic [5:0] op, input logic [2:0] ty,
        input logic [1:0] md, input logic [2:0] kind, input logic flt,
        input logic [1:0] am, input logic [5:0] fl);
        return '{{op, 5'h03, 5'h04, ty, ty[0], ty[1] ? 12'hffc : 12'h024},
                 md, kind, flt, am, fl};
    endfunction

    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 100);
        chk(t < 100 && s_axi_bresp === 2'h0, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 100);
        chk(t < 100 && s_axi_rdata === e && s_axi_rresp === er, "read");
        s_axi_rready <= 1'b0;
    endtask

    task automatic check_row(input pmd_row_s r);
        pmd_pkg::pmd_dec_s o;
        o = dec_out;
        chk(o.valid === 1'b1 && o.kind === r.kind, "kind");
        chk(o.fault === r.flt && reserved_opcode_fault === r.flt, "fault");
        chk(o.eff_addr === base_value + {{52{r.instr[11]}}, r.instr[11:0]},
            "address");
        if (r.kind == k_ld || r.kind == k_st) begin
            chk(o.data_reg === r.instr[25:21] && o.base_reg === r.instr[20:16]
                && o.quad === r.instr[12] && o.acc_type === r.instr[15:13]
                && o.align_trap_en === 1'b0, "fields");
            chk(o.amode === r.am && {o.lock, o.cond_store, o.pte_fetch,
                o.kern_check, o.prot_check, o.bad_store_type} === r.fl, "mode");
        end
    endtask

    // Issues the queued rows back to back, checking each one cycle later
    task automatic run();
        for (int i = 0; i <= q.size(); i++) begin
            @(posedge aclk);
            if (i < q.size()) begin
                issue_valid  <= 1'b1;
                issue_instr  <= q[i].instr;
                library_mode <= q[i].md[1];
                kernel_mode  <= q[i].md[0];
            end else begin
                issue_valid <= 1'b0;
            end
            #1;
            if (i > 0) check_row(q[i-1]);
        end
    endtask

    initial begin
        #100us;
        bad_count++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {aresetn, issue_valid, library_mode, kernel_mode} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, issue_instr} = '0;
        s_axi_wstrb = 4'hf;
        base_value = 64'h0000_8000_0000_0010;
        bad_count = 0;
        n_checks = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(irq === 1'b0 && dec_out.valid === 1'b0, "reset outputs");
        for (int a = 0; a < 16; a += 4) axr(4'(a), 32'h0, 2'h0);
        q = '{mk(6'h1b, 3'h0, 2'b10, k_ld, 1'b0, 2'h0, 6'h00),
              mk(6'h1b, 3'h1, 2'b10, k_ld, 1'b0, 2'h0, 6'h20),
              mk(6'h1b, 3'h2, 2'b10, k_ld, 1'b0, 2'h1, 6'h0c),
              mk(6'h1b, 3'h3, 2'b10, k_ld, 1'b0, 2'h1, 6'h00),
              mk(6'h1b, 3'h4, 2'b10, k_ld, 1'b0, 2'h1, 6'h00),
              mk(6'h1b, 3'h5, 2'b10, k_ld, 1'b0, 2'h1, 6'h02),
              mk(6'h1b, 3'h6, 2'b10, k_ld, 1'b0, 2'h2, 6'h00),
              mk(6'h1b, 3'h7, 2'b10, k_ld, 1'b0, 2'h2, 6'h02),
              mk(6'h1f, 3'h0, 2'b10, k_st, 1'b0, 2'h0, 6'h00),
              mk(6'h1f, 3'h1, 2'b10, k_st, 1'b0, 2'h0, 6'h10),
              mk(6'h1f, 3'h2, 2'b10, k_st, 1'b0, 2'h1, 6'h00),
              mk(6'h1f, 3'h6, 2'b10, k_st, 1'b0, 2'h2, 6'h00),
              // unused store code, kept only to probe the flag
              mk(6'h1f, 3'h3, 2'b10, k_st, 1'b0, 2'h0, 6'h01),
              mk(6'h1e, 3'h0, 2'b10, k_rt, 1'b0, 2'h0, 6'h00),
              mk(6'h19, 3'h0, 2'b10, pmd_pkg::PMD_IREAD, 1'b0, 2'h0, 6'h00),
              mk(6'h1d, 3'h0, 2'b10, pmd_pkg::PMD_IWRITE, 1'b0, 2'h0, 6'h00),
              mk(6'h10, 3'h0, 2'b00, k_no, 1'b0, 2'h0, 6'h00),
              mk(6'h1b, 3'h0, 2'b00, k_no, 1'b1, 2'h0, 6'h00),
              mk(6'h1f, 3'h0, 2'b01, k_no, 1'b1, 2'h0, 6'h00),
              mk(6'h1e, 3'h0, 2'b00, k_no, 1'b1, 2'h0, 6'h00),
              mk(6'h19, 3'h0, 2'b00, k_no, 1'b1, 2'h0, 6'h00),
              mk(6'h1d, 3'h0, 2'b01, k_no, 1'b1, 2'h0, 6'h00)};
        run();
        axr(4'h4, 32'hf, 2'h0);
        axr(4'hc, 32'h5, 2'h0);
        chk(irq === 1'b0, "masked interrupt");
        axw(4'h8, 32'h1);
        #1;
        chk(irq === 1'b1, "interrupt raised");
        axw(4'h4, 32'h1);
        #1;
        chk(irq === 1'b0, "interrupt cleared");
        axr(4'h4, 32'he, 2'h0);
        axw(4'hc, 32'h0);
        axr(4'hc, 32'h0, 2'h0);
        axr(4'h6, 32'h0, 2'h2);
        axw(4'h0, 32'h1);
        axr(4'h0, 32'h1, 2'h0);
        q = '{mk(6'h1b, 3'h5, 2'b01, k_ld, 1'b0, 2'h1, 6'h02),
              mk(6'h1e, 3'h0, 2'b00, k_no, 1'b1, 2'h0, 6'h00),
              mk(6'h1f, 3'h6, 2'b01, k_st, 1'b0, 2'h2, 6'h00)};
        run();
        results();
    end
endmodule
